// ---- hdl/edhd_consts.svh ----
`ifndef EDHD_CONSTS_SVH
`define EDHD_CONSTS_SVH

// Register subaddresses
`define EDHD_ADDR_MODE1     8'h30
`define EDHD_ADDR_MODE2     8'h31
`define EDHD_ADDR_MODE3     8'h32

// Reset values
`define EDHD_RST_MODE1      8'h00
`define EDHD_RST_MODE2      8'h00
`define EDHD_RST_MODE3      3'h0
`define EDHD_RD_NONE        8'h00

// Mode register 1 fields
`define EDHD_STD_LSB        0
`define EDHD_STD_MSB        1
`define EDHD_SYNC_BIT       2
`define EDHD_MODE_LSB       3
`define EDHD_MODE_MSB       7

// Mode register 2 fields
`define EDHD_PDV_BIT        0
`define EDHD_RSV2_BIT       1
`define EDHD_TPEN_BIT       2
`define EDHD_TPTYPE_BIT     3
`define EDHD_VBI_BIT        4
`define EDHD_USL_LSB        5
`define EDHD_USL_MSB        6
`define EDHD_SHARP_BIT      7

// Mode register 3 fields
`define EDHD_YDLY_LSB       0
`define EDHD_YDLY_MSB       2
`define EDHD_YDLY_LAST      3'h3
`define EDHD_YDLY_SEL_LAST  2'h3

// Output standard codes
`define EDHD_STD_770_23     2'h0
`define EDHD_STD_770_1      2'h1
`define EDHD_STD_FULL       2'h2

// Test pattern levels and grid
`define EDHD_TP_WHITE       10'h3ac
`define EDHD_TP_BLACK       10'h040
`define EDHD_TP_FLAT        10'h1f4
`define EDHD_TP_CHROMA      10'h200
`define EDHD_TP_GRID        4'h0

`endif

// ---- hdl/edhd_luma_delay.sv ----
`timescale 1ns/1ps

module edhd_luma_delay #(
    parameter int W     = 10,
    parameter int DEPTH = 4
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rstn_i,
    input  wire logic [W-1:0]             din_i,
    input  wire logic [$clog2(DEPTH)-1:0] sel_i,
    output logic      [W-1:0]             dout_o
);

    logic [W-1:0] taps_q [DEPTH];
    logic [W-1:0] taps_d [DEPTH];

    // Shift chain, one stage per tap
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_tap
        if (i == 0)
        begin : g_head
            always_comb
            begin
                taps_d[i] = din_i;
            end
        end
        else
        begin : g_link
            always_comb
            begin
                taps_d[i] = taps_q[i-1];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int k = 0; k < DEPTH; k++)
            begin
                taps_q[k] <= '0;
            end
        end
        else
        begin
            for (int k = 0; k < DEPTH; k++)
            begin
                taps_q[k] <= taps_d[k];
            end
        end
    end

    assign dout_o = taps_q[sel_i];

endmodule

// ---- hdl/edhd_mode_config_registers.sv ----
`timescale 1ns/1ps
`include "edhd_consts.svh"

module edhd_mode_config_registers
    import edhd_pkg::*;
#(
    parameter int W     = 10,
    parameter int DEPTH = 4
) (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    output logic      [7:0]   reg_rdata_o,
    input  wire logic         hsync_pin_i,
    input  wire logic         vsync_pin_i,
    input  wire logic         field_pin_i,
    input  wire logic [W-1:0] y_pin_i,
    input  wire logic [W-1:0] c_pin_i,
    input  wire logic         emb_hsync_i,
    input  wire logic         emb_vref_i,
    input  wire logic         vsync_field_sel_i,
    output logic [W-1:0]      y_o,
    output logic [W-1:0]      c_o,
    output logic              hsync_o,
    output logic              vref_o,
    output level_t            level_o,
    output fmt_t              fmt_o,
    output logic              fmt_rsvd_o,
    output logic              pdv_en_o,
    output logic              vbi_open_o,
    output logic [1:0]        undershoot_o,
    output logic              sharpness_o
);

    logic [7:0]   mode1_q, mode1_d;
    logic [7:0]   mode2_q, mode2_d;
    logic [2:0]   ydly_q, ydly_d;
    logic [7:0]   rdata_q, rdata_d;
    logic         hs1_q, hs2_q, vs1_q, vs2_q, fl1_q, fl2_q;
    logic [W-1:0] y1_q, y2_q, c1_q, c2_q;
    logic [10:0]  pix_q, pix_d, line_q, line_d;
    logic         hs_prev_q, hs_prev_d;
    logic [W-1:0] cdl_q, cdl_d, c_q, c_d, y_q, y_d;
    logic         hsdl_q, hsdl_d, hs_q, hs_d, vrdl_q, vrdl_d, vr_q, vr_d;
    logic         hs_sel, vr_sel, hs_fall, tp_en, tp_type, hd;
    logic [W-1:0] tp_y, y_src, y_dly;
    logic [4:0]   mode;
    logic [1:0]   dly_sel;

    // Register group
    always_comb
    begin
        mode1_d = mode1_q;
        mode2_d = mode2_q;
        ydly_d  = ydly_q;
        rdata_d = rdata_q;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `EDHD_ADDR_MODE1: mode1_d = reg_wdata_i;
                `EDHD_ADDR_MODE2:
                begin
                    mode2_d = reg_wdata_i;
                    mode2_d[`EDHD_RSV2_BIT] = 1'b0;
                end
                `EDHD_ADDR_MODE3: ydly_d = reg_wdata_i[`EDHD_YDLY_MSB:`EDHD_YDLY_LSB];
                default: ;
            endcase
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `EDHD_ADDR_MODE1: rdata_d = mode1_q;
                `EDHD_ADDR_MODE2: rdata_d = mode2_q;
                `EDHD_ADDR_MODE3: rdata_d = {5'h00, ydly_q};
                default:          rdata_d = `EDHD_RD_NONE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode1_q <= `EDHD_RST_MODE1;
            mode2_q <= `EDHD_RST_MODE2;
            ydly_q  <= `EDHD_RST_MODE3;
            rdata_q <= `EDHD_RD_NONE;
        end
        else
        begin
            mode1_q <= mode1_d;
            mode2_q <= mode2_d;
            ydly_q  <= ydly_d;
            rdata_q <= rdata_d;
        end
    end

    // Field decode
    assign mode         = mode1_q[`EDHD_MODE_MSB:`EDHD_MODE_LSB];
    assign pdv_en_o     = mode2_q[`EDHD_PDV_BIT];
    assign tp_en        = mode2_q[`EDHD_TPEN_BIT];
    assign tp_type      = mode2_q[`EDHD_TPTYPE_BIT];
    assign vbi_open_o   = mode2_q[`EDHD_VBI_BIT];
    assign undershoot_o = mode2_q[`EDHD_USL_MSB:`EDHD_USL_LSB];
    assign sharpness_o  = mode2_q[`EDHD_SHARP_BIT];
    assign reg_rdata_o  = rdata_q;
    assign fmt_rsvd_o   = (fmt_o == FMT_RSVD);
    assign hd = (fmt_o == FMT_720P) || (fmt_o == FMT_1035I) || (fmt_o == FMT_1080I)
             || (fmt_o == FMT_1080P) || (fmt_o == FMT_1080PSF);

    always_comb
    begin
        case (mode)
            5'h00, 5'h02:        fmt_o = FMT_525P;
            5'h01:               fmt_o = FMT_NONSTD;
            5'h03, 5'h04:        fmt_o = FMT_625P;
            5'h05, 5'h06, 5'h07,
            5'h08, 5'h09:        fmt_o = FMT_720P;
            5'h0a:               fmt_o = FMT_1035I;
            5'h0d, 5'h0e:        fmt_o = FMT_1080I;
            5'h0f, 5'h10, 5'h11: fmt_o = FMT_1080P;
            5'h12:               fmt_o = FMT_1080PSF;
            default:             fmt_o = FMT_RSVD;
        endcase
    end

    always_comb
    begin
        case (mode1_q[`EDHD_STD_MSB:`EDHD_STD_LSB])
            `EDHD_STD_770_23: level_o = hd ? LVL_EIA770_3 : LVL_EIA770_2;
            `EDHD_STD_770_1:  level_o = LVL_EIA770_1;
            `EDHD_STD_FULL:   level_o = LVL_FULL;
            default:          level_o = LVL_RSVD;
        endcase
    end

    // Pin synchronisers
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            {hs1_q, hs2_q, vs1_q, vs2_q, fl1_q, fl2_q} <= 6'h00;
            {y1_q, y2_q, c1_q, c2_q} <= '0;
        end
        else
        begin
            {hs1_q, vs1_q, fl1_q} <= {hsync_pin_i, vsync_pin_i, field_pin_i};
            {hs2_q, vs2_q, fl2_q} <= {hs1_q, vs1_q, fl1_q};
            {y1_q, c1_q} <= {y_pin_i, c_pin_i};
            {y2_q, c2_q} <= {y1_q, c1_q};
        end
    end

    // Sync source and pattern
    assign hs_sel  = mode1_q[`EDHD_SYNC_BIT] ? emb_hsync_i : hs2_q;
    assign vr_sel  = mode1_q[`EDHD_SYNC_BIT] ? emb_vref_i
                   : (vsync_field_sel_i ? vs2_q : fl2_q);
    assign hs_fall = hs_prev_q && !hs_sel;
    assign tp_y    = tp_type ? `EDHD_TP_FLAT
                   : ((pix_q[3:0] == `EDHD_TP_GRID) || (line_q[3:0] == `EDHD_TP_GRID))
                     ? `EDHD_TP_WHITE : `EDHD_TP_BLACK;
    assign y_src   = tp_en ? tp_y : y2_q;
    assign dly_sel = (ydly_q > `EDHD_YDLY_LAST) ? `EDHD_YDLY_SEL_LAST : ydly_q[1:0];

    edhd_luma_delay #(
        .W     (W),
        .DEPTH (DEPTH)
    ) u_luma_delay (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .din_i  (y_src),
        .sel_i  (dly_sel),
        .dout_o (y_dly)
    );

    // Video group
    always_comb
    begin
        hs_prev_d = hs_sel;
        pix_d     = hs_fall ? 11'h000 : pix_q + 11'h001;
        line_d    = hs_fall ? line_q + 11'h001 : line_q;
        cdl_d     = tp_en ? `EDHD_TP_CHROMA : c2_q;
        c_d       = cdl_q;
        hsdl_d    = hs_sel;
        hs_d      = hsdl_q;
        vrdl_d    = vr_sel;
        vr_d      = vrdl_q;
        y_d       = y_dly;
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hs_prev_q <= 1'b0;
            pix_q     <= 11'h000;
            line_q    <= 11'h000;
            cdl_q     <= '0;
            c_q       <= '0;
            hsdl_q    <= 1'b0;
            hs_q      <= 1'b0;
            vrdl_q    <= 1'b0;
            vr_q      <= 1'b0;
            y_q       <= '0;
        end
        else
        begin
            hs_prev_q <= hs_prev_d;
            pix_q     <= pix_d;
            line_q    <= line_d;
            cdl_q     <= cdl_d;
            c_q       <= c_d;
            hsdl_q    <= hsdl_d;
            hs_q      <= hs_d;
            vrdl_q    <= vrdl_d;
            vr_q      <= vr_d;
            y_q       <= y_d;
        end
    end

    assign y_o     = y_q;
    assign c_o     = c_q;
    assign hsync_o = hs_q;
    assign vref_o  = vr_q;

    a_mode1_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == `EDHD_ADDR_MODE1 |=> mode1_q == $past(reg_wdata_i))
        else $error("mode register 1 did not take write");
    a_level_full: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mode1_q[`EDHD_STD_MSB:`EDHD_STD_LSB] == `EDHD_STD_FULL |-> level_o == LVL_FULL)
        else $error("full range level not selected");
    a_sync_embedded: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mode1_q[`EDHD_SYNC_BIT] && $stable(mode1_q) |-> ##2 hsync_o == $past(emb_hsync_i, 2))
        else $error("embedded hsync not used");
    a_vref_pins: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !mode1_q[`EDHD_SYNC_BIT] && !vsync_field_sel_i ##1 !mode1_q[`EDHD_SYNC_BIT]
        |=> vref_o == $past(fl2_q, 2))
        else $error("field pin not routed to vref");
    a_pdv_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == `EDHD_ADDR_MODE2 |=> pdv_en_o == $past(reg_wdata_i[0]))
        else $error("pixel data valid bit wrong");
    a_video_pass: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!tp_en && ydly_q == 3'h0) [*3] |-> y_o == $past(y2_q, 2))
        else $error("input video not passed through");
    a_tp_flat: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        tp_en && tp_type |-> y_src == `EDHD_TP_FLAT)
        else $error("flat pattern level wrong");
    a_tp_hatch: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        tp_en && !tp_type && pix_q[3:0] == `EDHD_TP_GRID |-> y_src == `EDHD_TP_WHITE)
        else $error("hatch line missing");
    a_luma_delay3: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (ydly_q == 3'h3) [*6] |-> y_o == $past(y_src, 5))
        else $error("luma delay of three not applied");
    a_fmt_reserved: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        mode == 5'h0b || mode == 5'h13 |-> fmt_rsvd_o)
        else $error("reserved input mode not flagged");
    a_unmapped_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i > `EDHD_ADDR_MODE3 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

endmodule

// ---- hdl/edhd_pkg.sv ----
package edhd_pkg;

    typedef enum logic [2:0] {
        LVL_EIA770_2,
        LVL_EIA770_3,
        LVL_EIA770_1,
        LVL_FULL,
        LVL_RSVD
    } level_t;

    typedef enum logic [3:0] {
        FMT_525P,
        FMT_NONSTD,
        FMT_625P,
        FMT_720P,
        FMT_1035I,
        FMT_1080I,
        FMT_1080P,
        FMT_1080PSF,
        FMT_RSVD
    } fmt_t;

endpackage

// ---- verification/serial_host_model.sv ----
`timescale 1ns/1ps

module serial_host_model (
    input  wire logic       mclk_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial
    begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // Byte write, then scramble the idle bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge mclk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // Byte read, data taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge mclk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        @(negedge mclk_i);
        d = reg_rdata_i;
    endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps

module tb_top
    import edhd_pkg::*;
;
    logic        clk, rstn, wr, rd, hs, vs, fl, eh, ev, sel;
    logic        hso, vro, rsv, pdv, vbi, shp;
    logic [1:0]  us;
    logic [7:0]  addr, wdat, rdat;
    logic [9:0]  yp, cp, yo, co;
    level_t      lvl;
    fmt_t        fmt;
    int          fails, compares;
    logic [31:0] seed = 32'd69728;

    edhd_mode_config_registers DUT (
        .mclk_i(clk), .rstn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat),
        .hsync_pin_i(hs), .vsync_pin_i(vs), .field_pin_i(fl), .y_pin_i(yp),
        .c_pin_i(cp), .emb_hsync_i(eh), .emb_vref_i(ev), .vsync_field_sel_i(sel),
        .y_o(yo), .c_o(co), .hsync_o(hso), .vref_o(vro), .level_o(lvl),
        .fmt_o(fmt), .fmt_rsvd_o(rsv), .pdv_en_o(pdv), .vbi_open_o(vbi),
        .undershoot_o(us), .sharpness_o(shp)
    );

    serial_host_model host (
        .mclk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdat), .reg_rdata_i(rdat)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic fmt_t exp_fmt(input logic [4:0] c);
        case (c)
            5'h00, 5'h02: return FMT_525P;
            5'h01: return FMT_NONSTD;
            5'h03, 5'h04: return FMT_625P;
            5'h05, 5'h06, 5'h07, 5'h08, 5'h09: return FMT_720P;
            5'h0a: return FMT_1035I;
            5'h0d, 5'h0e: return FMT_1080I;
            5'h0f, 5'h10, 5'h11: return FMT_1080P;
            5'h12: return FMT_1080PSF;
            default: return FMT_RSVD;
        endcase
    endfunction

    function automatic level_t exp_lvl(input logic [1:0] s, input fmt_t f);
        logic hd;
        hd = f inside {FMT_720P, FMT_1035I, FMT_1080I, FMT_1080P, FMT_1080PSF};
        case (s)
            2'h0: return hd ? LVL_EIA770_3 : LVL_EIA770_2;
            2'h1: return LVL_EIA770_1;
            2'h2: return LVL_FULL;
            default: return LVL_RSVD;
        endcase
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cycles from a pixel change to its arrival on luma and chroma
    task automatic lag(input logic [9:0] v, output int ny, output int nc);
        ny = 0;
        nc = 0;
        @(posedge clk);
        yp <= v;
        cp <= ~v;
        for (int i = 1; i <= 14; i++)
        begin
            @(negedge clk);
            if (ny == 0 && yo === v)
                ny = i;
            if (nc == 0 && co === ~v)
                nc = i;
        end
    endtask

    initial
    begin
        #200us;
        fails++;
        $display("MISMATCH watchdog expected done seen timeout");
        test_done();
    end

    initial
    begin
        logic [7:0] d, e, v8;
        logic [9:0] v;
        int         a, b, c, a0, w;
        {rstn, hs, vs, fl, eh, ev, sel} = 7'h00;
        yp = 10'h000;
        cp = 10'h000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("level", LVL_EIA770_2, lvl);
        chk("fmt", FMT_525P, fmt);
        chk("pdv", 1'b0, pdv);
        for (a = 0; a < 4; a++)
        begin
            host.rd(8'(8'h30 + a), d);
            chk("reset value", 8'h00, d);
        end
        $display("test reset done");
        for (int k = 0; k < 14; k++)
        begin
            v8 = (k == 0) ? 8'hff : 8'(rnd());
            a = (k == 0) ? 1 : int'(rnd() % 4);
            host.wr(8'(8'h30 + a), v8);
            host.rd(8'(8'h30 + a), d);
            e = (a == 0) ? v8 : (a == 1) ? (v8 & 8'hfd) : (a == 2) ? (v8 & 8'h07) : 8'h00;
            chk("register", e, d);
            if (a == 1)
            begin
                chk("pdv", v8[0], pdv);
                chk("sharp", {v8[7], v8[6:5], v8[4]}, {shp, us, vbi});
            end
        end
        $display("test registers done");
        for (a = 0; a < 128; a++)
        begin
            host.wr(8'h30, {a[6:2], 1'b0, a[1:0]});
            @(negedge clk);
            chk("fmt", exp_fmt(a[6:2]), fmt);
            chk("fmt_rsvd", exp_fmt(a[6:2]) == FMT_RSVD, rsv);
            if (exp_fmt(a[6:2]) != FMT_RSVD)
                chk("level", exp_lvl(a[1:0], exp_fmt(a[6:2])), lvl);
        end
        $display("test decode done");
        for (a = 0; a < 8; a++)
        begin
            host.wr(8'h30, {5'h00, a[0], 2'h0});
            @(posedge clk);
            v8 = 8'(rnd());
            {ev, eh, fl, vs, hs} <= v8[4:0];
            sel <= a[1];
            repeat (8) @(negedge clk);
            chk("hsync", a[0] ? v8[3] : v8[0], hso);
            chk("vref", a[0] ? v8[4] : (a[1] ? v8[1] : v8[2]), vro);
        end
        $display("test sync done");
        host.wr(8'h31, 8'h00);
        for (a = 0; a < 8; a++)
        begin
            host.wr(8'h32, 8'(a));
            v = 10'(rnd());
            lag(~v, b, c);
            lag(v, b, c);
            if (a == 0)
                a0 = b;
            chk("luma lag", a0 + ((a > 3) ? 3 : a), b);
            chk("chroma lag", a0, c);
        end
        $display("test delay done");
        host.wr(8'h31, 8'h0c);
        repeat (8) @(negedge clk);
        chk("flat", 10'h1f4, yo);
        chk("chroma", 10'h200, co);
        host.wr(8'h31, 8'h04);
        repeat (8) @(negedge clk);
        w = 0;
        repeat (40)
        begin
            @(negedge clk);
            chk("hatch", 1'b1, yo == 10'h3ac || yo == 10'h040);
            if (yo == 10'h3ac)
                w++;
        end
        chk("hatch grid", 1'b1, w >= 2);
        host.wr(8'h31, 8'h00);
        repeat (10) @(negedge clk);
        chk("video", yp, yo);
        $display("test pattern done");
        test_done();
    end
endmodule
